/* File: shared/camor_params.svh */
/*
 Constants of the camera output routing block: byte addresses, field positions (bit 0 of a control word is
 the most significant bit, so positions here are hrdata indices), reset values and timing counts.
 Assumes a 250 MHz clock and one aligned 32-bit word per register.
*/
`ifndef CAMOR_PARAMS_SVH
`define CAMOR_PARAMS_SVH

`define CAMOR_OUT1_ADDR     32'hf1000320
`define CAMOR_OUT2_ADDR     32'hf1000324
`define CAMOR_DLY_ADDR      32'hf1000340

`define CAMOR_PRES_POS      31
`define CAMOR_POL_POS       24
`define CAMOR_MODE_MSB      20
`define CAMOR_MODE_LSB      16
`define CAMOR_PIN_POS       0
`define CAMOR_DLY_ON_POS    25
`define CAMOR_DLY_W         21

`define CAMOR_POL_RST       1'b0
`define CAMOR_PIN_RST       1'b0
`define CAMOR_DLY_ON_RST    1'b0
`define CAMOR_DLY_RST       21'h000000

`define CAMOR_CLK_PERIOD_NS 4
`define CAMOR_US_NS         1000
`define CAMOR_US_CYC        ((`CAMOR_US_NS + `CAMOR_CLK_PERIOD_NS - 1) / `CAMOR_CLK_PERIOD_NS)
`define CAMOR_DELAY_MAX_MS  1050
`define CAMOR_DELAY_MAX_US  (`CAMOR_DELAY_MAX_MS * 1000)
`define CAMOR_TOGGLE_HZ     700
`define CAMOR_CLK_HZ        (1000000000 / `CAMOR_CLK_PERIOD_NS)
`define CAMOR_TOGGLE_CYC    ((`CAMOR_CLK_HZ + `CAMOR_TOGGLE_HZ - 1) / `CAMOR_TOGGLE_HZ)

`endif

/* File: shared/camor_pkg.sv */
/*
 Types of the camera output routing block: routing mode codes, register select and delay states.
 Assumes camor_params.svh is on the include path.
*/
`include "camor_params.svh"
package camor_pkg;
	typedef logic [4:0] camor_mode_t;
	typedef logic [`CAMOR_DLY_W-1:0] camor_delay_t;

	localparam camor_mode_t CAMOR_MODE_OFF    = 5'h00;
	localparam camor_mode_t CAMOR_MODE_DIRECT = 5'h01;
	localparam camor_mode_t CAMOR_MODE_EXPO   = 5'h02;
	localparam camor_mode_t CAMOR_MODE_FRAME  = 5'h06;
	localparam camor_mode_t CAMOR_MODE_BUSY   = 5'h07;
	localparam camor_mode_t CAMOR_MODE_MIRROR = 5'h08;

	typedef enum {CAMOR_REG_NONE, CAMOR_REG_OUT1, CAMOR_REG_OUT2, CAMOR_REG_DLY} camor_reg_e;
	typedef enum {CAMOR_DLY_IDLE, CAMOR_DLY_WAIT, CAMOR_DLY_ON} camor_dly_e;
endpackage

/* File: shared/camor_line_if.sv */
/*
 Carrier between the register block and one output line: configuration and candidate signals in,
 resulting pin level out. Assumes all signals are on hclk.
*/
`timescale 1ns/1ps
interface camor_line_if;
	camor_pkg::camor_mode_t mode;
	logic                   invert;
	logic                   level_sw;
	logic                   exposure;
	logic                   frame;
	logic                   busy;
	logic                   mirror;
	logic                   pin;

	modport ctrl (output mode, output invert, output level_sw, output exposure, output frame, output busy,
		output mirror, input pin);
	modport line (input mode, input invert, input level_sw, input exposure, input frame, input busy,
		input mirror, output pin);
endinterface

/* File: hw/camor_delay.sv */
/*
 Leading-edge delay of the exposure indication, counted in microsecond ticks.
 Assumes us_tick is a one-cycle pulse every microsecond and exposure is on hclk.
*/
`timescale 1ns/1ps
`include "camor_params.svh"
module camor_delay (
	input  wire logic                 hclk,     // Clock
	input  wire logic                 hresetn,  // Async reset, active low
	input  wire logic                 us_tick,  // One pulse per microsecond
	input  wire logic                 exposure, // Sensor exposure in progress
	input  wire logic                 delay_en, // Delay switched on
	input  wire camor_pkg::camor_delay_t delay_us, // Delay in microseconds
	output logic                      active_q  // Delayed exposure indication
);
	camor_pkg::camor_dly_e   state_q;
	camor_pkg::camor_dly_e   state_d;
	camor_pkg::camor_delay_t cnt_q;
	camor_pkg::camor_delay_t cnt_d;
	logic                    active_d;

	// Tick phase is free running, so a delay may come up short by up to one microsecond
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			camor_pkg::CAMOR_DLY_IDLE:
				if (exposure)
				begin
					cnt_d = '0;
					if (!delay_en || delay_us == '0)
						state_d = camor_pkg::CAMOR_DLY_ON;
					else
						state_d = camor_pkg::CAMOR_DLY_WAIT;
				end
			camor_pkg::CAMOR_DLY_WAIT:
				if (!exposure)
					state_d = camor_pkg::CAMOR_DLY_IDLE;
				else if (us_tick)
				begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_d >= delay_us)
						state_d = camor_pkg::CAMOR_DLY_ON;
				end
			camor_pkg::CAMOR_DLY_ON:
				if (!exposure)
					state_d = camor_pkg::CAMOR_DLY_IDLE;
			default:
				state_d = camor_pkg::CAMOR_DLY_IDLE;
		endcase
		active_d = (state_d == camor_pkg::CAMOR_DLY_ON);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q  <= camor_pkg::CAMOR_DLY_IDLE;
			cnt_q    <= '0;
			active_q <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			active_q <= active_d;
		end
	end

	sequence s_rise_nodelay;
		$rose(exposure) && (!delay_en || delay_us == '0);
	endsequence

	property p_lead_now;
		@(posedge hclk) disable iff (!hresetn) s_rise_nodelay |=> active_q;
	endproperty

	a_lead_nodelay: assert property (p_lead_now)
		else $error("exposure indication not raised one cycle after exposure start");

	a_trail_follow: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(exposure) |=> !active_q)
		else $error("exposure indication outlived exposure");

	a_no_spurious: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(active_q) |-> $past(exposure))
		else $error("exposure indication raised without exposure");
endmodule

/* File: hw/camor_line.sv */
/*
 One output line: selects the routed signal by mode, applies polarity and limits software toggling.
 Assumes the candidate signals arrive on hclk, the mirrored input already synchronised.
*/
`timescale 1ns/1ps
`include "camor_params.svh"
module camor_line #(
	parameter int TOGGLE_CYC = `CAMOR_TOGGLE_CYC // Least cycles between software driven pin changes
) (
	input  wire logic hclk,    // Clock
	input  wire logic hresetn, // Async reset, active low
	camor_line_if.line lif     // Configuration in, pin level out
);
	localparam int CW = $clog2(TOGGLE_CYC + 1);

	logic          routed;
	logic          target;
	logic          direct;
	logic          pin_q;
	logic          pin_d;
	logic [CW-1:0] hold_q;
	logic [CW-1:0] hold_d;

	always_comb
	begin
		case (lif.mode)
			camor_pkg::CAMOR_MODE_DIRECT: routed = lif.level_sw;
			camor_pkg::CAMOR_MODE_EXPO:   routed = lif.exposure;
			camor_pkg::CAMOR_MODE_FRAME:  routed = lif.frame;
			camor_pkg::CAMOR_MODE_BUSY:   routed = lif.busy;
			camor_pkg::CAMOR_MODE_MIRROR: routed = lif.mirror;
			default:                      routed = 1'b0;
		endcase
		target = routed ^ lif.invert;
		direct = (lif.mode == camor_pkg::CAMOR_MODE_DIRECT);
	end

	// Only software driven changes load the holdoff; routed hardware signals pass at full rate
	always_comb
	begin
		pin_d  = pin_q;
		hold_d = hold_q;
		if (hold_q != '0)
			hold_d = hold_q - 1'b1;
		if (!direct)
			pin_d = target;
		else if (hold_q == '0 && target != pin_q)
		begin
			pin_d  = target;
			hold_d = CW'(TOGGLE_CYC - 1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_q  <= 1'b0;
			hold_q <= '0;
		end
		else
		begin
			pin_q  <= pin_d;
			hold_q <= hold_d;
		end
	end

	assign lif.pin = pin_q;

	a_hold_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
		(direct && hold_q != '0) |=> $stable(pin_q))
		else $error("software driven pin changed during holdoff");

	a_change_loads: assert property (@(posedge hclk) disable iff (!hresetn)
		($changed(pin_q) && $past(direct)) |-> hold_q == CW'(TOGGLE_CYC - 1))
		else $error("software driven change did not start holdoff");

	a_off_inactive: assert property (@(posedge hclk) disable iff (!hresetn)
		(lif.mode == camor_pkg::CAMOR_MODE_OFF) |=> pin_q == $past(lif.invert))
		else $error("off mode did not drive the inactive level");

	a_busy_route: assert property (@(posedge hclk) disable iff (!hresetn)
		(lif.mode == camor_pkg::CAMOR_MODE_BUSY) |=> pin_q == ($past(lif.busy) ^ $past(lif.invert)))
		else $error("busy mode pin does not match busy and polarity");
endmodule

/* File: hw/camor_top.sv */
/*
 Camera output routing: two output control words and an exposure delay word behind an AHB-Lite slave,
 the status signal derivation and two output lines.
 Assumes exposure, readout and transmit status come from logic on hclk; input pins are asynchronous.
*/
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "camor_params.svh"
module camor_top #(
	parameter int TOGGLE_CYC   = `CAMOR_TOGGLE_CYC,  // Least cycles between software pin changes
	parameter int DELAY_MAX_US = `CAMOR_DELAY_MAX_US // Largest accepted delay in microseconds
) (
	input  wire logic        hclk,         // Clock, 250 MHz
	input  wire logic        hresetn,      // Async reset, active low
	input  wire logic        hsel,         // Slave select
	input  wire logic [31:0] haddr,        // Byte address
	input  wire logic [1:0]  htrans,       // Transfer type
	input  wire logic        hwrite,       // Write when high
	input  wire logic [2:0]  hsize,        // Transfer size, word only
	input  wire logic [31:0] hwdata,       // Write data
	input  wire logic        hready,       // Bus ready
	output logic             hreadyout,    // Slave ready
	output logic [31:0]      hrdata,       // Read data
	output logic             hresp,        // Response, always OKAY
	input  wire logic        exposure_in,  // Sensor exposure in progress
	input  wire logic        readout_in,   // Sensor readout in progress
	input  wire logic        transmit_in,  // Image data transmission active
	input  wire logic [1:0]  in_line_pin,  // Input line levels, asynchronous
	output logic [1:0]       out_line_pin  // Output stage drive, high turns transistor on
);
	logic                    accept;
	camor_pkg::camor_reg_e   asel;
	camor_pkg::camor_reg_e   wsel_q;
	camor_pkg::camor_reg_e   wsel_d;
	logic                    wen_q;
	logic                    wen_d;
	logic [31:0]             rdata_q;
	logic [31:0]             rdata_d;
	camor_pkg::camor_mode_t  mode_q [2];
	camor_pkg::camor_mode_t  mode_d [2];
	logic [1:0]              inv_q;
	logic [1:0]              inv_d;
	logic [1:0]              lvl_q;
	logic [1:0]              lvl_d;
	logic                    dly_on_q;
	logic                    dly_on_d;
	camor_pkg::camor_delay_t dly_us_q;
	camor_pkg::camor_delay_t dly_us_d;
	logic [7:0]              div_q;
	logic [7:0]              div_d;
	logic                    us_tick;
	logic [1:0]              in_meta_q;
	logic [1:0]              in_sync_q;
	logic                    integration_active;
	logic                    frame_valid_out;
	logic                    busy;
	logic [1:0]              pin_now;

	localparam camor_pkg::camor_delay_t DLY_MAX = `CAMOR_DLY_W'(DELAY_MAX_US);
	localparam logic [7:0]              US_LAST = 8'(`CAMOR_US_CYC - 1);

	camor_line_if lif [2] ();

	function automatic camor_pkg::camor_reg_e decode(input logic [31:0] addr);
		case (addr)
			`CAMOR_OUT1_ADDR: decode = camor_pkg::CAMOR_REG_OUT1;
			`CAMOR_OUT2_ADDR: decode = camor_pkg::CAMOR_REG_OUT2;
			`CAMOR_DLY_ADDR:  decode = camor_pkg::CAMOR_REG_DLY;
			default:          decode = camor_pkg::CAMOR_REG_NONE;
		endcase
	endfunction

	// Control word as software sees it; hrdata bit 0 shows the live pin, not the stored drive bit
	function automatic logic [31:0] line_word(input camor_pkg::camor_mode_t mode, input logic inv,
		input logic pin);
		logic [31:0] w;
		w = 32'h00000000;
		w[`CAMOR_PRES_POS] = 1'b1;
		w[`CAMOR_POL_POS] = inv;
		w[`CAMOR_MODE_MSB:`CAMOR_MODE_LSB] = mode;
		w[`CAMOR_PIN_POS] = pin;
		return w;
	endfunction

	assign accept    = hsel & hready & htrans[1];
	assign asel      = decode(haddr);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	always_comb
	begin
		wen_d   = accept & hwrite;
		wsel_d  = asel;
		rdata_d = rdata_q;
		if (accept && !hwrite)
		begin
			case (asel)
				camor_pkg::CAMOR_REG_OUT1: rdata_d = line_word(mode_q[0], inv_q[0], pin_now[0]);
				camor_pkg::CAMOR_REG_OUT2: rdata_d = line_word(mode_q[1], inv_q[1], pin_now[1]);
				camor_pkg::CAMOR_REG_DLY:
				begin
					rdata_d = 32'h00000000;
					rdata_d[`CAMOR_PRES_POS] = 1'b1;
					rdata_d[`CAMOR_DLY_ON_POS] = dly_on_q;
					rdata_d[`CAMOR_DLY_W-1:0] = dly_us_q;
				end
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_comb
	begin
		mode_d   = mode_q;
		inv_d    = inv_q;
		lvl_d    = lvl_q;
		dly_on_d = dly_on_q;
		dly_us_d = dly_us_q;
		if (wen_q)
		begin
			case (wsel_q)
				camor_pkg::CAMOR_REG_OUT1, camor_pkg::CAMOR_REG_OUT2:
				begin
					mode_d[wsel_q == camor_pkg::CAMOR_REG_OUT2] = hwdata[`CAMOR_MODE_MSB:`CAMOR_MODE_LSB];
					inv_d[wsel_q == camor_pkg::CAMOR_REG_OUT2]  = hwdata[`CAMOR_POL_POS];
					lvl_d[wsel_q == camor_pkg::CAMOR_REG_OUT2]  = hwdata[`CAMOR_PIN_POS];
				end
				camor_pkg::CAMOR_REG_DLY:
				begin
					dly_on_d = hwdata[`CAMOR_DLY_ON_POS];
					if (hwdata[`CAMOR_DLY_W-1:0] > DLY_MAX)
						dly_us_d = DLY_MAX;
					else
						dly_us_d = hwdata[`CAMOR_DLY_W-1:0];
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wen_q     <= 1'b0;
			wsel_q    <= camor_pkg::CAMOR_REG_NONE;
			rdata_q   <= 32'h00000000;
			mode_q[0] <= camor_pkg::CAMOR_MODE_EXPO;
			mode_q[1] <= camor_pkg::CAMOR_MODE_BUSY;
			inv_q     <= {2{`CAMOR_POL_RST}};
			lvl_q     <= {2{`CAMOR_PIN_RST}};
			dly_on_q  <= `CAMOR_DLY_ON_RST;
			dly_us_q  <= `CAMOR_DLY_RST;
		end
		else
		begin
			wen_q    <= wen_d;
			wsel_q   <= wsel_d;
			rdata_q  <= rdata_d;
			mode_q   <= mode_d;
			inv_q    <= inv_d;
			lvl_q    <= lvl_d;
			dly_on_q <= dly_on_d;
			dly_us_q <= dly_us_d;
		end
	end

	// Microsecond enable for the delay counter
	always_comb
	begin
		us_tick = (div_q == US_LAST);
		div_d   = us_tick ? 8'h00 : div_q + 8'h01;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_q     <= 8'h00;
			in_meta_q <= 2'h0;
			in_sync_q <= 2'h0;
		end
		else
		begin
			div_q     <= div_d;
			in_meta_q <= in_line_pin;
			in_sync_q <= in_meta_q;
		end
	end

	camor_delay u_delay (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.us_tick  (us_tick),
		.exposure (exposure_in),
		.delay_en (dly_on_q),
		.delay_us (dly_us_q),
		.active_q (integration_active)
	);

	assign frame_valid_out = readout_in;
	assign busy            = exposure_in | readout_in | transmit_in;

	for (genvar gi = 0; gi < 2; gi++)
	begin : g_line
		assign lif[gi].mode     = mode_q[gi];
		assign lif[gi].invert   = inv_q[gi];
		assign lif[gi].level_sw = lvl_q[gi];
		assign lif[gi].exposure = integration_active;
		assign lif[gi].frame    = frame_valid_out;
		assign lif[gi].busy     = busy;
		assign lif[gi].mirror   = in_sync_q[gi];
		assign pin_now[gi]      = lif[gi].pin;
		assign out_line_pin[gi] = lif[gi].pin;

		camor_line #(
			.TOGGLE_CYC (TOGGLE_CYC)
		) u_line (
			.hclk    (hclk),
			.hresetn (hresetn),
			.lif     (lif[gi])
		);
	end

	a_presence_read: assert property (@(posedge hclk) disable iff (!hresetn)
		(accept && !hwrite && asel != camor_pkg::CAMOR_REG_NONE) |=> hrdata[`CAMOR_PRES_POS])
		else $error("presence flag not read as one");

	a_unmapped_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		(accept && !hwrite && asel == camor_pkg::CAMOR_REG_NONE) |=> hrdata == 32'h00000000)
		else $error("unmapped read returned nonzero data");

	a_pin_readback: assert property (@(posedge hclk) disable iff (!hresetn)
		(accept && !hwrite && asel == camor_pkg::CAMOR_REG_OUT2) |=> hrdata[`CAMOR_PIN_POS] == $past(out_line_pin[1]))
		else $error("pin state read back does not match output");

	a_mode_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wen_q && wsel_q == camor_pkg::CAMOR_REG_OUT1)
		|=> mode_q[0] == $past(hwdata[`CAMOR_MODE_MSB:`CAMOR_MODE_LSB]) && $stable(mode_q[1]))
		else $error("line 1 mode write wrong or leaked to line 2");

	a_delay_clamp: assert property (@(posedge hclk) disable iff (!hresetn)
		dly_us_q <= DLY_MAX)
		else $error("stored delay exceeds maximum");

	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hreadyout && !hresp)
		else $error("slave stalled or answered with error");
endmodule

/* File: verification/camor_ext_equip.sv */
/*
 External equipment on the two output lines: a strobe that counts flashes on line 1, and the source of
 the two input lines. Assumes line levels as driven by the output stage; input lines change off the clock.
*/
`timescale 1ns/1ps
module camor_ext_equip (
	input  wire logic [1:0] line_lvl,  // Output line levels seen by the equipment
	input  wire logic [1:0] in_cmd,    // Level the equipment wants on the input lines
	output logic [1:0]      in_pin,    // Input line levels, unrelated in phase to the clock
	output int              flash_cnt  // Strobe firings on line 1
);
	initial
	begin
		flash_cnt = 0;
		in_pin = 2'h0;
	end
	// A low level means the transistor is off, so only a rising level fires the strobe
	always @(posedge line_lvl[0]) flash_cnt++;
	// Skew keeps input edges away from the sampling edge
	always @(in_cmd) in_pin <= #1.3 in_cmd;
endmodule

/* File: verification/camor_top_tb.sv */
/*
 Self-checking bench of the camera output routing block: AHB-Lite master tasks, queued expectations
 checked by a monitor, and the external equipment model. Assumes the design files and headers are compiled first.
*/
`timescale 1ns/1ps
`include "camor_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module camor_top_tb;
	localparam int TOG  = 16;
	localparam int DMAX = 20;
	localparam int US   = `CAMOR_US_CYC;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        exposure_in, readout_in, transmit_in, pol, p1, p2;
	logic [31:0] haddr, hwdata, hrdata, exp_v;
	logic [1:0]  htrans, in_cmd, in_line_pin, out_line_pin, take;
	logic [2:0]  hsize;
	logic [4:0]  m1, m2;
	logic [7:0]  sv;
	logic [4:0]  modes [8] = '{5'h00, 5'h02, 5'h03, 5'h06, 5'h07, 5'h08, 5'h09, 5'h1f};
	logic [31:0] exp_q [$];
	int          err_total, n_tests, flash_cnt, fbase, seed_v;

	camor_top #(.TOGGLE_CYC(TOG), .DELAY_MAX_US(DMAX)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .exposure_in(exposure_in),
		.readout_in(readout_in), .transmit_in(transmit_in), .in_line_pin(in_line_pin),
		.out_line_pin(out_line_pin));
	camor_ext_equip equip (.line_lvl(out_line_pin), .in_cmd(in_cmd), .in_pin(in_line_pin),
		.flash_cnt(flash_cnt));

	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk)
	begin
		if (take != 2'd0)
		begin
			exp_v = exp_q.pop_front();
			case (take)
				2'd1: `CHK({hresp, hrdata}, {1'b0, exp_v})
				2'd2: `CHK(out_line_pin, exp_v[1:0])
				default: `CHK(flash_cnt, exp_v)
			endcase
		end
	end

	task automatic end_sim;
		$display("counts: %0d compares, %0d mismatches", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wait_rdy;
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && i < 64)
		begin
			@(posedge hclk);
			i++;
		end
		if (i >= 64)
		begin
			err_total++;
			end_sim();
		end
	endtask

	// A read notes its expected word; the monitor takes it at the data phase edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'b010;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h0;
		if (!wr)
		begin
			exp_q.push_back(d);
			take <= 2'd1;
		end
		wait_rdy();
		take <= 2'd0;
	endtask

	task automatic note(input logic [1:0] k, input logic [31:0] e);
		@(posedge hclk);
		exp_q.push_back(e);
		take <= k;
		@(posedge hclk);
		take <= 2'd0;
	endtask

	function automatic logic [31:0] ctl(input logic pl, input logic [4:0] m, input logic pin);
		return {1'b1, 6'h0, pl, 3'h0, m, 15'h0, pin};
	endfunction

	function automatic logic route(input logic [4:0] m, input logic e, r, t, inl);
		case (m)
			5'h02: return e;
			5'h06: return r;
			5'h07: return e | r | t;
			5'h08: return inl;
			default: return 1'b0;
		endcase
	endfunction

	initial
	begin
		#400000;
		err_total++;
		end_sim();
	end

	initial
	begin
		{hresetn, hsel, hwrite, exposure_in, readout_in, transmit_in} = 6'h0;
		{haddr, hwdata, htrans, in_cmd, take, hsize} = '0;
		err_total = 0;
		n_tests = 0;
		seed_v = $urandom(4853);
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, `CAMOR_OUT1_ADDR, ctl(0, 5'h02, 0));
		bus(0, `CAMOR_OUT2_ADDR, ctl(0, 5'h07, 0));
		bus(0, `CAMOR_DLY_ADDR, 32'h8000_0000);
		bus(1, `CAMOR_OUT1_ADDR + 32'h8, 32'hffff_ffff);
		bus(0, `CAMOR_OUT1_ADDR + 32'h8, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 16; i++)
		begin
			m1 = modes[i % 8];
			m2 = modes[(i + 3) % 8];
			pol = i[3];
			sv = 8'($urandom);
			{in_cmd, transmit_in, readout_in, exposure_in} <= sv[4:0];
			bus(1, `CAMOR_OUT1_ADDR, {7'h0, pol, 3'h0, m1, 16'h0});
			bus(1, `CAMOR_OUT2_ADDR, {7'h0, pol, 3'h0, m2, 16'h0});
			repeat (6) @(posedge hclk);
			p1 = route(m1, sv[0], sv[1], sv[2], sv[3]) ^ pol;
			p2 = route(m2, sv[0], sv[1], sv[2], sv[4]) ^ pol;
			note(2, {30'h0, p2, p1});
			bus(0, `CAMOR_OUT1_ADDR, ctl(pol, m1, p1));
			bus(0, `CAMOR_OUT2_ADDR, ctl(pol, m2, p2));
		end
		$display("test routing modes done");
		{exposure_in, readout_in, transmit_in} <= 3'h0;
		// Park line 1 low first, so the first software level is a real change that starts the holdoff
		bus(1, `CAMOR_OUT1_ADDR, 32'h0);
		bus(1, `CAMOR_OUT2_ADDR, 32'h0);
		bus(1, `CAMOR_OUT1_ADDR, 32'h0001_0001);
		bus(1, `CAMOR_OUT1_ADDR, 32'h0001_0000);
		note(2, 32'h1);
		repeat (TOG + 4) @(posedge hclk);
		note(2, 32'h0);
		bus(0, `CAMOR_OUT1_ADDR, ctl(0, 5'h01, 0));
		$display("test direct drive done");
		bus(1, `CAMOR_DLY_ADDR, 32'h021f_ffff);
		bus(0, `CAMOR_DLY_ADDR, 32'h8200_0000 | 32'(DMAX));
		bus(1, `CAMOR_DLY_ADDR, 32'h0200_0002);
		bus(1, `CAMOR_OUT1_ADDR, 32'h0002_0000);
		fbase = flash_cnt;
		exposure_in <= 1'b1;
		repeat (100) @(posedge hclk);
		exposure_in <= 1'b0;
		repeat (8) @(posedge hclk);
		note(3, 32'(fbase));
		exposure_in <= 1'b1;
		repeat (200) @(posedge hclk);
		note(2, 32'h0);
		repeat (2 * US) @(posedge hclk);
		note(2, 32'h1);
		exposure_in <= 1'b0;
		@(posedge hclk);
		note(2, 32'h0);
		note(3, 32'(fbase + 1));
		$display("test exposure delay done");
		end_sim();
	end
endmodule
